//--- core/ppw_pkg.sv
// Constants, register map and field layout for the parallel port timing block.
// Assumes one 25 MHz clock; a peripheral clock period is one clock cycle.
// ************************************************************
// Overview of operation
// ************************************************************
package ppw_pkg;
    // ************************************************************
    // Register offsets (byte addresses)
    // ************************************************************
    localparam logic [7:0] OFS_MODE = 8'h00; // Timing and mode settings
    localparam logic [7:0] OFS_CTRL = 8'h04; // Select pin function
    localparam logic [7:0] OFS_ADDR = 8'h08; // Address and chip selects
    localparam logic [7:0] OFS_DOUT = 8'h0c; // Slave output word
    localparam logic [7:0] OFS_DIN = 8'h10; // Master data / slave input
    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int POS_END = 0; // End hold wait field, 2 bits
    localparam int POS_MID = 2; // Strobe middle wait count, 4 bits
    localparam int POS_SETUP = 6; // Setup wait field, 2 bits
    localparam int POS_PMODE = 8; // Port mode, 2 bits
    localparam int POS_WIDE = 10; // Wide transfer select
    localparam int POS_STEP = 11; // Address step mode, 2 bits
    localparam int POS_BUSY = 15; // Busy flag, read only
    localparam int POS_SELFN = 6; // Select pin function, 2 bits
    localparam int POS_CS2 = 15; // Second select active
    localparam int POS_CS1 = 14; // First select active
    // ************************************************************
    // Reset values and encodings
    // ************************************************************
    localparam logic [31:0] RST_REG = 32'h0000_0000; // All registers
    localparam logic [15:0] ADDR_MASK = 16'hffff; // Implemented address bits
    localparam logic [1:0] STEP_NONE = 2'h0; // No stepping
    localparam logic [1:0] STEP_INC = 2'h1; // Increment per cycle
    localparam logic [1:0] STEP_DEC = 2'h2; // Decrement per cycle
    localparam logic [1:0] PM_LEGACY = 2'h0; // Legacy slave
    localparam logic [1:0] PM_ADDRSLV = 2'h1; // Addressable slave
    localparam logic [1:0] PM_MSEP = 2'h2; // Master, separate strobes
    localparam logic [1:0] PM_MCOMB = 2'h3; // Master, rw plus enable
    localparam logic [1:0] SF_ADDR = 2'h0; // Both pins address
    localparam logic [1:0] SF_ONE = 2'h1; // Upper pin select only
    localparam logic [1:0] SF_BOTH = 2'h2; // Both pins selects
    localparam logic [3:0] FIXED_SETUP = 4'h1; // Setup when middle is zero
    localparam logic [3:0] FIXED_WR_HOLD = 4'h1; // Write hold when middle zero
    localparam logic [3:0] FIXED_RD_HOLD = 4'h0; // Read hold when middle zero
    // Master cycle phases
    typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_SETUP, ST_STROBE, ST_HOLD} ppw_state_t;
endpackage : ppw_pkg

//--- core/ppw_port.sv
// Wait-state sequencer, address/select register and data registers of the port.
// Assumes a plain one-cycle register port and asynchronous external pins.
`timescale 1ns/1ps
module ppw_port (
    input wire logic clock, // 25 MHz system clock
    input wire logic srst, // Synchronous reset, active high
    input wire logic [7:0] regAddr, // Register byte address
    input wire logic [31:0] regWdata, // Register write data
    input wire logic regWr, // Write strobe
    input wire logic regRd, // Read strobe
    output logic [31:0] regRdata, // Read data, cycle after strobe
    output logic [15:0] addrPins, // External address lines / selects
    output logic [15:0] dataPinsOut, // External data lines, out value
    output logic [15:0] dataPinsOe, // External data lines, drive enable
    input wire logic [15:0] dataPinsIn, // External data lines, in value
    output logic strobeA, // Read strobe, or rw select in mode 11
    output logic strobeB, // Write strobe, or enable in mode 11
    input wire logic slvSelIn, // External master chip select
    input wire logic slvRdIn // External master read strobe
);
    import ppw_pkg::*;

    // ************************************************************
    // Helpers
    // ************************************************************
    // Setup code to cycle count
    function automatic logic [3:0] setupLen(input logic [1:0] code);
        setupLen = {2'b00, code} + 4'h1;
    endfunction : setupLen

    // Step the address while keeping select bits untouched
    function automatic logic [15:0] stepAddr(input logic [15:0] a, input logic [1:0] mode,
                                             input logic [1:0] fn);
        logic [15:0] keep;
        logic [15:0] nxt;
        keep = (fn == SF_BOTH) ? 16'hc000 : (fn == SF_ONE) ? 16'h8000 : 16'h0000;
        nxt = a;
        if (mode == STEP_INC) begin
            nxt = a + 16'h0001;
        end else if (mode == STEP_DEC) begin
            nxt = a - 16'h0001;
        end
        stepAddr = (a & keep) | (nxt & ~keep);
    endfunction : stepAddr

    // ************************************************************
    // State
    // ************************************************************
    logic [15:0] modeReg_q, modeReg_d; // Mode and timing settings
    logic [1:0] selFn_q, selFn_d; // Select pin function
    logic [15:0] addrReg_q, addrReg_d; // Address and selects
    logic [31:0] dout_q, dout_d; // Slave output word
    logic [31:0] din_q, din_d; // Input data word
    logic [31:0] regRdata_q, regRdata_d; // Read data register
    ppw_state_t state_q, state_d; // Master cycle phase
    logic [3:0] cnt_q, cnt_d; // Cycles left in phase
    logic isRead_q, isRead_d; // Current cycle is a read
    logic [15:0] wrData_q, wrData_d; // Data of a write cycle
    logic [15:0] dinSync1_q, dinSync2_q; // Data pin synchroniser
    logic [1:0] slvSync1_q, slvSync2_q; // Slave strobe synchroniser
    logic [15:0] addrPins_q, addrPins_d; // Registered pins
    logic [15:0] dOut_q, dOut_d; // Registered data out
    logic [15:0] dOe_q, dOe_d; // Registered data enable
    logic strobeA_q, strobeA_d; // Registered strobe A
    logic strobeB_q, strobeB_d; // Registered strobe B

    // Decoded fields
    logic [1:0] fSetup, fEnd, fPmode, fStep;
    logic [3:0] fMid;
    logic fWide, isMaster, busy, launch, cycleDone;
    logic [3:0] setupCyc, holdCyc, strobeCyc;

    assign fSetup = modeReg_q[POS_SETUP +: 2];
    assign fEnd = modeReg_q[POS_END +: 2];
    assign fMid = modeReg_q[POS_MID +: 4];
    assign fPmode = modeReg_q[POS_PMODE +: 2];
    assign fStep = modeReg_q[POS_STEP +: 2];
    assign fWide = modeReg_q[POS_WIDE];
    assign isMaster = fPmode[1];
    assign busy = (state_q != ST_IDLE);
    // Middle count of zero overrides both wait fields
    assign setupCyc = (fMid == 4'h0) ? FIXED_SETUP : setupLen(fSetup);
    assign holdCyc = (fMid == 4'h0) ? (isRead_q ? FIXED_RD_HOLD : FIXED_WR_HOLD)
                                    : {3'b000, fEnd[0]};
    // A zero middle count still needs one strobe cycle
    assign strobeCyc = (fMid == 4'h0) ? 4'h1 : fMid;
    // Data register access launches a master cycle when idle
    assign launch = isMaster && !busy && (regAddr == OFS_DIN) && (regWr || regRd);
    assign cycleDone = ((state_q == ST_HOLD) && (cnt_q == 4'h0))
                    || ((state_q == ST_STROBE) && (cnt_q == 4'h0) && (holdCyc == 4'h0));

    // ************************************************************
    // Register file and master sequencer
    // ************************************************************
    // Next values of registers and phase
    always_comb begin
        modeReg_d = modeReg_q;
        selFn_d = selFn_q;
        addrReg_d = addrReg_q;
        dout_d = dout_q;
        din_d = din_q;
        regRdata_d = 32'h0000_0000;
        state_d = state_q;
        cnt_d = cnt_q;
        isRead_d = isRead_q;
        wrData_d = wrData_q;
        // Software writes; busy flag is read only
        if (regWr) begin
            unique case (regAddr)
                OFS_MODE: modeReg_d = {1'b0, regWdata[14:0]};
                OFS_CTRL: selFn_d = regWdata[POS_SELFN +: 2];
                OFS_ADDR: addrReg_d = regWdata[15:0] & ADDR_MASK;
                OFS_DOUT: dout_d = regWdata;
                OFS_DIN: din_d = regWdata;
                default: ; // Unmapped writes are dropped
            endcase
        end
        // Reads answer next cycle; unmapped reads give zero
        if (regRd) begin
            unique case (regAddr)
                OFS_MODE: regRdata_d = {16'h0000, busy, modeReg_q[14:0]};
                OFS_CTRL: regRdata_d = {24'h00_0000, selFn_q, 6'h00};
                OFS_ADDR: regRdata_d = {16'h0000, addrReg_q};
                OFS_DOUT: regRdata_d = dout_q;
                OFS_DIN: regRdata_d = din_q;
                default: regRdata_d = 32'h0000_0000;
            endcase
        end
        // Phase sequencing
        unique case (state_q)
            ST_IDLE: begin
                if (launch) begin
                    state_d = ST_ADDR;
                    isRead_d = regRd;
                    wrData_d = regWdata[15:0];
                    cnt_d = setupCyc - 4'h1;
                end
            end
            ST_ADDR: begin
                if (cnt_q == 4'h0) begin
                    state_d = ST_SETUP;
                    cnt_d = setupCyc - 4'h1;
                end else begin
                    cnt_d = cnt_q - 4'h1;
                end
            end
            ST_SETUP: begin
                if (cnt_q == 4'h0) begin
                    state_d = ST_STROBE;
                    cnt_d = strobeCyc - 4'h1;
                end else begin
                    cnt_d = cnt_q - 4'h1;
                end
            end
            ST_STROBE: begin
                if (cnt_q == 4'h0) begin
                    // Read data sampled on the last strobe cycle
                    if (isRead_q) begin
                        din_d = {16'h0000, dinSync2_q[15:8] & {8{fWide}}, dinSync2_q[7:0]};
                    end
                    state_d = (holdCyc == 4'h0) ? ST_IDLE : ST_HOLD;
                    cnt_d = holdCyc - 4'h1;
                end else begin
                    cnt_d = cnt_q - 4'h1;
                end
            end
            ST_HOLD: begin
                if (cnt_q == 4'h0) begin
                    state_d = ST_IDLE;
                end else begin
                    cnt_d = cnt_q - 4'h1;
                end
            end
        endcase
        // One step per finished transfer; hardware step beats a software write
        if (cycleDone) begin
            addrReg_d = stepAddr(addrReg_q, fStep, selFn_q);
        end
    end

    // Register the state; reset takes constants only
    always_ff @(posedge clock) begin
        if (srst) begin
            modeReg_q <= RST_REG[15:0];
            selFn_q <= RST_REG[1:0];
            addrReg_q <= RST_REG[15:0];
            dout_q <= RST_REG;
            din_q <= RST_REG;
            regRdata_q <= RST_REG;
            state_q <= ST_IDLE;
            cnt_q <= 4'h0;
            isRead_q <= 1'b0;
            wrData_q <= 16'h0000;
        end else begin
            modeReg_q <= modeReg_d;
            selFn_q <= selFn_d;
            addrReg_q <= addrReg_d;
            dout_q <= dout_d;
            din_q <= din_d;
            regRdata_q <= regRdata_d;
            state_q <= state_d;
            cnt_q <= cnt_d;
            isRead_q <= isRead_d;
            wrData_q <= wrData_d;
        end
    end

    // ************************************************************
    // Pin logic
    // ************************************************************
    // Two-stage synchronisers; only stage two is read
    always_ff @(posedge clock) begin
        if (srst) begin
            dinSync1_q <= 16'h0000;
            dinSync2_q <= 16'h0000;
            slvSync1_q <= 2'h0;
            slvSync2_q <= 2'h0;
        end else begin
            dinSync1_q <= dataPinsIn;
            dinSync2_q <= dinSync1_q;
            slvSync1_q <= {slvSelIn, slvRdIn};
            slvSync2_q <= slvSync1_q;
        end
    end

    // Pin values; outputs registered to keep them glitch free
    always_comb begin
        logic strobeOn;
        strobeOn = (state_q == ST_STROBE);
        addrPins_d = addrReg_q;
        // Top pins follow select bits only when mapped as selects
        if (selFn_q != SF_ADDR) begin
            addrPins_d[15] = addrReg_q[POS_CS2];
        end
        if (selFn_q == SF_BOTH) begin
            addrPins_d[14] = addrReg_q[POS_CS1];
        end
        dOut_d = 16'h0000;
        dOe_d = 16'h0000;
        strobeA_d = 1'b0;
        strobeB_d = 1'b0;
        if (isMaster && busy && !isRead_q) begin
            dOut_d = wrData_q;
            dOe_d = {{8{fWide}}, 8'hff};
        end else if (!isMaster && (slvSync2_q == 2'b11)) begin
            dOut_d = {8'h00, dout_q[7:0]};
            dOe_d = 16'h00ff;
        end
        if (fPmode == PM_MSEP) begin
            strobeA_d = strobeOn && isRead_q;
            strobeB_d = strobeOn && !isRead_q;
        end else if (fPmode == PM_MCOMB) begin
            strobeA_d = busy && isRead_q;
            strobeB_d = strobeOn;
        end
    end

    // Output flip-flops
    always_ff @(posedge clock) begin
        if (srst) begin
            addrPins_q <= 16'h0000;
            dOut_q <= 16'h0000;
            dOe_q <= 16'h0000;
            strobeA_q <= 1'b0;
            strobeB_q <= 1'b0;
        end else begin
            addrPins_q <= addrPins_d;
            dOut_q <= dOut_d;
            dOe_q <= dOe_d;
            strobeA_q <= strobeA_d;
            strobeB_q <= strobeB_d;
        end
    end

    assign regRdata = regRdata_q;
    assign addrPins = addrPins_q;
    assign dataPinsOut = dOut_q;
    assign dataPinsOe = dOe_q;
    assign strobeA = strobeA_q;
    assign strobeB = strobeB_q;

    // ************************************************************
    // Assertions
    // ************************************************************
    property p_setup_len;
        @(posedge clock) disable iff (srst)
        (state_q == ST_IDLE && launch && fMid != 4'h0 && fSetup == 2'h3)
            |=> (state_q == ST_ADDR)[*4] ##1 (state_q == ST_SETUP)[*4] ##1 state_q == ST_STROBE;
    endproperty
    a_setup_len: assert property (p_setup_len) else $error("setup length wrong");

    property p_end_hold;
        @(posedge clock) disable iff (srst)
        (state_q == ST_STROBE && cnt_q == 4'h0 && fMid != 4'h0 && fEnd == 2'h1)
            |=> state_q == ST_HOLD ##1 state_q == ST_IDLE;
    endproperty
    a_end_hold: assert property (p_end_hold) else $error("end hold wrong");

    property p_fixed_read;
        @(posedge clock) disable iff (srst)
        (state_q == ST_STROBE && cnt_q == 4'h0 && fMid == 4'h0 && isRead_q)
            |=> state_q == ST_IDLE;
    endproperty
    a_fixed_read: assert property (p_fixed_read) else $error("read hold not zero");

    property p_sel_kept;
        @(posedge clock) disable iff (srst)
        (cycleDone && selFn_q == SF_BOTH && !regWr) |=> addrReg_q[15:14] == $past(addrReg_q[15:14]);
    endproperty
    a_sel_kept: assert property (p_sel_kept) else $error("select bits stepped");

    property p_upper_oe;
        @(posedge clock) disable iff (srst)
        (dataPinsOe[15:8] != 8'h00) |-> $past(fWide);
    endproperty
    a_upper_oe: assert property (p_upper_oe) else $error("upper data driven narrow");

    property p_step_one;
        @(posedge clock) disable iff (srst)
        (cycleDone && fStep == STEP_INC && selFn_q == SF_ADDR && !regWr)
            |=> addrReg_q == $past(addrReg_q) + 16'h0001;
    endproperty
    a_step_one: assert property (p_step_one) else $error("address step not one");

    property p_cs2_pin;
        @(posedge clock) disable iff (srst)
        $past(selFn_q) != SF_ADDR |-> addrPins[15] == $past(addrReg_q[POS_CS2]);
    endproperty
    a_cs2_pin: assert property (p_cs2_pin) else $error("second select pin wrong");

    property p_phase_order;
        @(posedge clock) disable iff (srst)
        $rose(state_q == ST_STROBE) |-> $past(state_q) == ST_SETUP;
    endproperty
    a_phase_order: assert property (p_phase_order) else $error("strobe out of order");
endmodule : ppw_port

//--- dv/ppw_ext_dev.sv
// Model of an external parallel device on the far side of the port pins.
// Assumes active-high strobes and the same clock as the port.
`timescale 1ns/1ps
// ************************************************************
// External device model
// ************************************************************
module ppw_ext_dev (
    input wire logic clock, // Shared 25 MHz clock
    input wire logic strobeA, // Read strobe or rw select from the port
    input wire logic [15:0] rdWord, // Word returned on reads
    input wire logic slvReq, // Bench asks for a slave-mode read
    output logic [15:0] dataPinsIn, // Data the device drives
    output logic slvSelIn, // Select toward the port
    output logic slvRdIn // Read strobe toward the port
);
    int holdCnt = 0; // Output hold left after the strobe drops
    logic [15:0] busVal = 16'h0000; // Value on the data lines, single driver
    // Drive read data while strobed, then hold briefly
    always @(posedge clock) begin
        if (strobeA) begin
            holdCnt <= 2;
            busVal <= rdWord;
        end else if (holdCnt > 0) begin
            holdCnt <= holdCnt - 1;
        end else begin
            // Released bus: toggle so a stale value never passes
            busVal <= ~busVal;
        end
    end
    assign dataPinsIn = busVal;
    // Acting as an external master in slave modes
    assign slvSelIn = slvReq;
    assign slvRdIn = slvReq;
endmodule : ppw_ext_dev

//--- dv/testbench.sv
// Self-checking bench for the port timing, address and data registers.
// Assumes the register map and field positions of ppw_pkg.
`timescale 1ns/1ps
module testbench;
    import ppw_pkg::*;
    // ************************************************************
    // Signals
    // ************************************************************
    logic clock = 1'b0; // Bench clock
    logic srst = 1'b1; // Held for the first 10 cycles
    logic [7:0] regAddr = 8'h00; // Register address
    logic [31:0] regWdata = 32'h0000_0000; // Register write data
    logic regWr = 1'b0; // Write strobe
    logic regRd = 1'b0; // Read strobe
    logic [31:0] regRdata; // Read data
    logic [15:0] addrPins, dataPinsOut, dataPinsOe, dataPinsIn; // External pins
    logic strobeA, strobeB, slvSelIn, slvRdIn; // Strobes and slave inputs
    logic slvReq = 1'b0; // Slave read request toward the model
    logic [15:0] rdWord = 16'h0000; // Device read word
    int n_mismatch = 0; // Mismatch count
    int cmp_count = 0; // Comparison count
    int cycles = 0; // Timeout counter
    always #20 clock = ~clock;
    ppw_port dut (.clock(clock), .srst(srst), .regAddr(regAddr), .regWdata(regWdata),
        .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .addrPins(addrPins),
        .dataPinsOut(dataPinsOut), .dataPinsOe(dataPinsOe), .dataPinsIn(dataPinsIn),
        .strobeA(strobeA), .strobeB(strobeB), .slvSelIn(slvSelIn), .slvRdIn(slvRdIn));
    ppw_ext_dev ext (.clock(clock), .strobeA(strobeA), .rdWord(rdWord), .slvReq(slvReq),
        .dataPinsIn(dataPinsIn), .slvSelIn(slvSelIn), .slvRdIn(slvRdIn));
    // ************************************************************
    // Shared tasks
    // ************************************************************
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    // One write cycle; returns at the edge that takes it
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        regWr <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge clock);
        regWr <= 1'b0;
    endtask : wr
    // One read cycle; data sampled in the following cycle only
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clock);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge clock);
        regRd <= 1'b0;
        #1 d = regRdata;
    endtask : rd
    function automatic logic [31:0] modeWord(int e, int m, int s, logic [1:0] pm,
        logic wide, logic [1:0] st);
        return (32'(e) << POS_END) | (32'(m) << POS_MID) | (32'(s) << POS_SETUP)
            | (32'(pm) << POS_PMODE) | (32'(wide) << POS_WIDE) | (32'(st) << POS_STEP);
    endfunction : modeWord
    // Run one master cycle and time its strobe, hold and data enables
    task automatic mcycle(input logic rdOp, input logic [1:0] pm, input logic wide,
        input logic [1:0] st, input int s, input int m, input int h, input logic [15:0] wd);
        logic [31:0] d;
        logic [15:0] oeExp, oeSeen, dSeen;
        logic en, dirSeen;
        int rise, wid, fall, oeOff, expS, expM, expH, wrong;
        rise = -1; wid = 0; fall = -1; oeOff = -1;
        wrong = 0; // Cycles with the unused strobe of mode 10 high
        oeExp = wide ? 16'hffff : 16'h00ff; // Upper pins only when wide
        expS = (m == 0) ? 1 : s + 1;
        expM = (m == 0) ? 1 : m;
        expH = (m == 0) ? (rdOp ? 0 : 1) : (h & 1);
        wr(OFS_MODE, modeWord(h, m, s, pm, wide, st));
        rdWord <= wd;
        if (rdOp) begin
            rd(OFS_DIN, d);
        end else begin
            wr(OFS_DIN, {16'h0000, wd});
            #1;
        end
        // Both request tasks return just after the launch edge, so k counts from it
        for (int k = 1; k < 45; k++) begin
            @(posedge clock);
            #1 en = (pm == PM_MCOMB) ? strobeB : (rdOp ? strobeA : strobeB);
            if (en) begin
                if (rise < 0) begin
                    rise = k;
                    oeSeen = dataPinsOe;
                    dSeen = dataPinsOut;
                    dirSeen = strobeA;
                end
                wid++;
            end else if (rise >= 0 && fall < 0) begin
                fall = k;
            end
            if (rise >= 0 && oeOff < 0 && dataPinsOe === 16'h0000) oeOff = k;
            if (pm == PM_MSEP && (rdOp ? strobeB : strobeA) !== 1'b0) wrong++;
        end
        chk(32'(rise), 32'(2 * expS + 1));
        chk(32'(wid), 32'(expM));
        if (pm == PM_MCOMB) chk({31'h0, dirSeen}, {31'h0, rdOp});
        chk(32'(wrong), 32'h0000_0000);
        if (!rdOp) begin
            chk(32'(oeOff - fall), 32'(expH));
            chk({16'h0, oeSeen}, {16'h0, oeExp});
            chk({16'h0, dSeen & oeExp}, {16'h0, wd & oeExp});
        end else if (m == 6) begin
            rd(OFS_DIN, d);
            chk(d, {16'h0, wd & oeExp});
            // That data read launched another external read; let it finish
            repeat (20) @(posedge clock);
        end
    endtask : mcycle
    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_regs;
        logic [31:0] d;
        for (int i = 0; i < 6; i++) begin
            rd(8'(i * 4), d);
            chk(d, RST_REG);
        end
        wr(8'h14, 32'hffff_ffff);
        rd(8'h14, d);
        chk(d, 32'h0000_0000);
        wr(OFS_MODE, 32'h0000_8000);
        rd(OFS_MODE, d);
        chk(d, 32'h0000_0000);
        wr(OFS_DOUT, 32'ha5c3_0f96);
        rd(OFS_DOUT, d);
        chk(d, 32'ha5c3_0f96);
        wr(OFS_CTRL, 32'(SF_BOTH) << POS_SELFN);
        wr(OFS_ADDR, 32'hffff_c123);
        rd(OFS_ADDR, d);
        chk(d, 32'h0000_c123);
        chk({16'h0, addrPins}, 32'h0000_c123);
        wr(OFS_ADDR, 32'h0000_2123);
        rd(OFS_ADDR, d);
        chk({16'h0, addrPins}, 32'h0000_2123);
        $display("test regs done");
    endtask : t_regs
    // Every setup code, end codes 0 and 1, middle zero, short and long strobes
    task automatic t_timing;
        int mids[3] = '{0, 1, 6};
        for (int s = 0; s < 4; s++)
            for (int h = 0; h < 2; h++)
                for (int j = 0; j < 3; j++)
                    for (int r = 0; r < 2; r++) begin
                        mcycle(r[0], PM_MSEP, 1'b0, STEP_NONE, s, mids[j], h, 16'h3c00 + 16'(s));
                    end
        mcycle(1'b0, PM_MSEP, 1'b1, STEP_NONE, 1, 2, 1, 16'habcd);
        mcycle(1'b1, PM_MSEP, 1'b1, STEP_NONE, 0, 6, 0, 16'h9e71);
        mcycle(1'b0, PM_MCOMB, 1'b0, STEP_NONE, 2, 3, 1, 16'h0042);
        mcycle(1'b1, PM_MCOMB, 1'b0, STEP_NONE, 0, 2, 0, 16'h0081);
        $display("test timing done");
    endtask : t_timing
    // Stepping with select bits excluded, both widths and directions
    task automatic t_step;
        logic [31:0] d;
        logic [1:0] fnT[5] = '{SF_BOTH, SF_BOTH, SF_ADDR, SF_ONE, SF_ADDR};
        logic [1:0] stT[5] = '{STEP_INC, STEP_DEC, STEP_INC, STEP_INC, STEP_NONE};
        logic wT[5] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b1};
        logic [15:0] stA[5] = '{16'hffff, 16'hc000, 16'h3fff, 16'hffff, 16'h1234};
        logic [15:0] exA[5] = '{16'hc000, 16'hffff, 16'h4000, 16'h8000, 16'h1234};
        for (int i = 0; i < 5; i++) begin
            wr(OFS_CTRL, 32'(fnT[i]) << POS_SELFN);
            wr(OFS_ADDR, {16'h0000, stA[i]});
            mcycle(1'b0, PM_MSEP, wT[i], stT[i], 0, 1, 0, 16'h00a5);
            rd(OFS_ADDR, d);
            chk(d, {16'h0000, exA[i]});
            chk({16'h0, addrPins}, {16'h0000, exA[i]});
        end
        $display("test step done");
    endtask : t_step
    // External master reads the output word in both slave modes
    task automatic t_slave;
        logic [1:0] pmT[2] = '{PM_LEGACY, PM_ADDRSLV};
        for (int i = 0; i < 2; i++) begin
            wr(OFS_MODE, modeWord(0, 0, 0, pmT[i], 1'b0, STEP_NONE));
            wr(OFS_DOUT, 32'h1234_565a);
            @(posedge clock);
            slvReq <= 1'b1;
            repeat (5) @(posedge clock);
            #1 chk({16'h0, dataPinsOe}, 32'h0000_00ff);
            chk({24'h0, dataPinsOut[7:0]}, 32'h0000_005a);
            @(posedge clock);
            slvReq <= 1'b0;
            repeat (5) @(posedge clock);
            #1 chk({16'h0, dataPinsOe}, 32'h0000_0000);
        end
        $display("test slave done");
    endtask : t_slave
    // ************************************************************
    // Ending and sequence
    // ************************************************************
    task automatic results;
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : results
    // Hang guard, far beyond the expected run
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            results();
        end
    end
    initial begin
        repeat (10) @(posedge clock);
        srst <= 1'b0;
        t_regs();
        t_timing();
        t_step();
        t_slave();
        results();
    end
endmodule : testbench
